// ==== src/prot_logic_pkg.sv ====
package prot_logic_pkg;
  // Wishbone register map, byte addresses of aligned 32-bit words
  localparam int ADR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00; // Write-one pulses
  localparam logic [7:0] OFS_PWR_THR_ONE = 8'h04; // Alarm one threshold
  localparam logic [7:0] OFS_PWR_THR_TWO = 8'h08; // Alarm two threshold
  localparam logic [7:0] OFS_PHASE_SECTOR = 8'h0c; // Phase sector start angle
  localparam logic [7:0] OFS_NEUTRAL_SECTOR = 8'h10; // Neutral sector start angle
  localparam logic [7:0] OFS_SLOW_TIME = 8'h14; // Slow breaker time, ms
  localparam logic [7:0] OFS_UV_SETTING = 8'h18; // Reclose undervoltage level
  localparam logic [7:0] OFS_UV_DELAY = 8'h1c; // Recovery delay, ms
  localparam logic [7:0] OFS_USER_OUT = 8'h20; // User logic outputs
  localparam logic [7:0] OFS_STATUS = 8'h24; // Read-only flags
  localparam logic [7:0] OFS_LATCH = 8'h28; // Read-only latch and seal state
  // Control register bit positions
  localparam int CTRL_SEAL_RESET = 0;
  localparam int CTRL_CLEAR_ALL = 1;
  // Status register field positions
  localparam int ST_ALARM_ONE = 0;
  localparam int ST_ALARM_TWO = 1;
  localparam int ST_BF_TRIP = 2;
  localparam int ST_BF_RETRIP = 3;
  localparam int ST_PHASE_DIR = 4;
  localparam int ST_NEUTRAL_DIR = 5;
  localparam int ST_SYNC = 6;
  localparam int ST_SLOW_BRK = 7;
  localparam int ST_UV_BLOCK = 8;
  localparam int ST_TAG = 9; // Three bits: off, tagged, on
  localparam int LT_SEAL = 8; // Seal-in bits above the eight latches
  // Reset values
  localparam logic [15:0] RST_PWR_THR = 16'hffff;
  localparam logic [8:0] RST_SECTOR = 9'h000;
  localparam logic [15:0] RST_SLOW_TIME = 16'h00c8;
  localparam logic [15:0] RST_UV_SETTING = 16'h0000;
  localparam logic [15:0] RST_UV_DELAY = 16'h03e8;
  localparam logic [15:0] RST_USER_OUT = 16'h0000;
  // Angles in whole degrees
  localparam logic [9:0] DEG_FULL = 10'h168;
  localparam logic [9:0] DEG_SECTOR = 10'h0b4;
  // Time base
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_NS = 1000000; // One tick per millisecond
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int ALARM_DELAY_S = 60;
  localparam int ALARM_DELAY_TICKS = ALARM_DELAY_S * (1000000000 / TICK_NS);
  // Hot hold tag states, one-hot
  typedef enum logic [2:0] {
    TAG_OFF = 3'h1,
    TAG_TAGGED = 3'h2,
    TAG_ON = 3'h4
  } tag_state_e;
  localparam tag_state_e TAG_INIT_RST = TAG_OFF;
endpackage

// ==== src/prot_logic.sv ====
// Operation
// - Alarm two asserts after sixty seconds above threshold
// - Dropping below threshold early clears the timer
// - Two power alarms with independent thresholds
// - Breaker failure trip flag follows trip event
// - Retrip flag follows retrip event
// - Phase flag while positive angle in sector
// - Neutral flag while negative angle in sector
// - Sync output equals sync condition
// - Slow breaker alarm after configured time
// - Undervoltage asserts block and suspends reclosing
// - Block releases after voltage recovers for delay
// - Eight latches set and reset by inputs
// - Sixteen user outputs, reset to zero
// - Off to on on tag release
// - On state permits reclose and manual close
// - Seal-in holds until seal reset command; the clear-all command drops it too
// - Off to tagged on tag set
// - Tagged or on return to off
// - Tagged state blocks the close output
//
// Added by the designer: register access over Wishbone and the placing of the registers.

// Pickup timer: counts ticks while its condition holds
module pickup_timer (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_tick,
  input wire logic i_clear,
  input wire logic i_cond,
  input wire logic [15:0] i_limit,
  output logic o_done
);
  logic [15:0] count; // Elapsed ticks

  // Count restarts whenever the condition drops
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count <= 16'h0000;
    end else if (i_ce) begin
      if (!i_cond || i_clear) begin
        count <= 16'h0000;
      end else if (i_tick && count < i_limit) begin
        count <= count + 16'h0001;
      end
    end
  end

  // Done only while the condition still holds
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_done <= 1'b0;
    end else if (i_ce) begin
      o_done <= i_cond && !i_clear && count >= i_limit;
    end
  end
endmodule

module prot_logic #(
  parameter int P_TICK_CYCLES = prot_logic_pkg::TICK_CYCLES,
  parameter int P_ALARM_TICKS = prot_logic_pkg::ALARM_DELAY_TICKS,
  parameter prot_logic_pkg::tag_state_e P_TAG_INIT = prot_logic_pkg::TAG_INIT_RST
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [prot_logic_pkg::ADR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [15:0] i_pos_power,
  input wire logic [8:0] i_pos_seq_angle,
  input wire logic [8:0] i_neg_seq_angle,
  input wire logic i_bf_trip_event,
  input wire logic i_bf_retrip_event,
  input wire logic i_sync_ok,
  input wire logic i_breaker_operating,
  input wire logic [15:0] i_voltage,
  input wire logic [7:0] i_latch_set,
  input wire logic [7:0] i_latch_reset,
  input wire logic i_tag_set_input,
  input wire logic i_tag_release_input,
  input wire logic i_manual_close,
  input wire logic i_reclose_request,
  output logic o_positive_power_alarm_one,
  output logic o_positive_power_alarm_two,
  output logic o_breaker_failure_trip_flag,
  output logic o_breaker_failure_retrip_flag,
  output logic o_phase_directional_flag,
  output logic o_neutral_directional_flag,
  output logic o_sync_check,
  output logic o_slow_breaker_alarm,
  output logic o_reclose_undervoltage_block,
  output logic [4:0] o_seal_in,
  output logic [7:0] o_latching_outputs,
  output logic [15:0] o_user_logic_outputs,
  output logic o_tag_off_state_output,
  output logic o_tag_tagged_state_output,
  output logic o_tag_on_state_output,
  output logic o_close_output,
  output logic o_reclose_output
);
  import prot_logic_pkg::*;

  logic [13:0] tick_cnt; // Divider for the millisecond time base
  logic tick; // One-cycle time base strobe
  logic [15:0] pwr_thr_one; // Alarm one threshold
  logic [15:0] pwr_thr_two; // Alarm two threshold
  logic [8:0] phase_start; // Phase sector start
  logic [8:0] neutral_start; // Neutral sector start
  logic [15:0] slow_time; // Slow breaker limit
  logic [15:0] uv_setting; // Undervoltage level
  logic [15:0] uv_delay; // Recovery delay
  logic seal_reset; // Pulse from control write
  logic clear_all; // Pulse from control write
  logic uv_recovered; // Recovery timer done
  logic [31:0] next_rd; // Read mux
  logic wb_req; // New bus request this cycle
  logic wb_wr; // Write strobe
  tag_state_e tag_state; // Hot hold tag machine state
  tag_state_e next_tag_state;
  logic [4:0] seal_base; // Sources of the seal-in alarms

  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr = wb_req && i_wb_we;

  // True when angle lies in the half plane that starts at the sector angle
  function automatic logic in_sector(input logic [8:0] a, input logic [8:0] s);
    logic [9:0] d;
    begin
      d = (a >= s) ? ({1'b0, a} - {1'b0, s}) : ({1'b0, a} + DEG_FULL - {1'b0, s});
      in_sector = d < DEG_SECTOR;
    end
  endfunction

  // Time base divider; stops with the clock enable like everything else
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_cnt <= 14'h0000;
      tick <= 1'b0;
    end else if (i_ce) begin
      if (tick_cnt == 14'(P_TICK_CYCLES - 1)) begin
        tick_cnt <= 14'h0000;
        tick <= 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 14'h0001;
        tick <= 1'b0;
      end
    end
  end

  // Bus slave: one wait state, ack for one cycle, unmapped reads give zero
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else if (i_ce) begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we) begin
        o_wb_dat <= next_rd;
      end
    end
  end

  // Settings writes, byte lanes honoured; low two lanes only carry data
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pwr_thr_one <= RST_PWR_THR;
      pwr_thr_two <= RST_PWR_THR;
      phase_start <= RST_SECTOR;
      neutral_start <= RST_SECTOR;
      slow_time <= RST_SLOW_TIME;
      uv_setting <= RST_UV_SETTING;
      uv_delay <= RST_UV_DELAY;
      o_user_logic_outputs <= RST_USER_OUT;
    end else if (i_ce && wb_wr) begin
      for (int b = 0; b < 2; b++) begin
        if (i_wb_sel[b]) begin
          case (i_wb_adr)
            OFS_PWR_THR_ONE: pwr_thr_one[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            OFS_PWR_THR_TWO: pwr_thr_two[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            OFS_SLOW_TIME: slow_time[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            OFS_UV_SETTING: uv_setting[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            OFS_UV_DELAY: uv_delay[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            OFS_USER_OUT: o_user_logic_outputs[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            default: ;
          endcase
        end
      end
      // Angles are nine bits wide and straddle two lanes
      if (i_wb_adr == OFS_PHASE_SECTOR && i_wb_sel[1:0] == 2'h3) begin
        phase_start <= i_wb_dat[8:0];
      end
      if (i_wb_adr == OFS_NEUTRAL_SECTOR && i_wb_sel[1:0] == 2'h3) begin
        neutral_start <= i_wb_dat[8:0];
      end
    end
  end

  // Control pulses last exactly one enabled cycle
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      seal_reset <= 1'b0;
      clear_all <= 1'b0;
    end else if (i_ce) begin
      seal_reset <= wb_wr && i_wb_adr == OFS_CTRL && i_wb_sel[0] && i_wb_dat[CTRL_SEAL_RESET];
      clear_all <= wb_wr && i_wb_adr == OFS_CTRL && i_wb_sel[0] && i_wb_dat[CTRL_CLEAR_ALL];
    end
  end

  // Read mux
  always_comb begin
    next_rd = 32'h0000_0000;
    case (i_wb_adr)
      OFS_PWR_THR_ONE: next_rd[15:0] = pwr_thr_one;
      OFS_PWR_THR_TWO: next_rd[15:0] = pwr_thr_two;
      OFS_PHASE_SECTOR: next_rd[8:0] = phase_start;
      OFS_NEUTRAL_SECTOR: next_rd[8:0] = neutral_start;
      OFS_SLOW_TIME: next_rd[15:0] = slow_time;
      OFS_UV_SETTING: next_rd[15:0] = uv_setting;
      OFS_UV_DELAY: next_rd[15:0] = uv_delay;
      OFS_USER_OUT: next_rd[15:0] = o_user_logic_outputs;
      OFS_STATUS: begin
        next_rd[ST_ALARM_ONE] = o_positive_power_alarm_one;
        next_rd[ST_ALARM_TWO] = o_positive_power_alarm_two;
        next_rd[ST_BF_TRIP] = o_breaker_failure_trip_flag;
        next_rd[ST_BF_RETRIP] = o_breaker_failure_retrip_flag;
        next_rd[ST_PHASE_DIR] = o_phase_directional_flag;
        next_rd[ST_NEUTRAL_DIR] = o_neutral_directional_flag;
        next_rd[ST_SYNC] = o_sync_check;
        next_rd[ST_SLOW_BRK] = o_slow_breaker_alarm;
        next_rd[ST_UV_BLOCK] = o_reclose_undervoltage_block;
        next_rd[ST_TAG +: 3] = tag_state;
      end
      OFS_LATCH: next_rd[LT_SEAL + 4:0] = {o_seal_in, o_latching_outputs};
      default: next_rd = 32'h0000_0000; // Unmapped and control read as zero
    endcase
  end

  // Delayed power alarms, one threshold each
  pickup_timer u_alarm_one (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_clear(clear_all),
    .i_cond(i_pos_power > pwr_thr_one),
    .i_limit(16'(P_ALARM_TICKS)),
    .o_done(o_positive_power_alarm_one)
  );

  pickup_timer u_alarm_two (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_clear(clear_all),
    .i_cond(i_pos_power > pwr_thr_two),
    .i_limit(16'(P_ALARM_TICKS)),
    .o_done(o_positive_power_alarm_two)
  );

  // Slow breaker: breaker still operating after the set time
  pickup_timer u_slow_brk (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_clear(clear_all),
    .i_cond(i_breaker_operating),
    .i_limit(slow_time),
    .o_done(o_slow_breaker_alarm)
  );

  // Voltage must stay above the setting for the whole delay
  pickup_timer u_uv_recover (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_ce(i_ce),
    .i_tick(tick),
    .i_clear(clear_all),
    .i_cond(i_voltage > uv_setting),
    .i_limit(uv_delay),
    .o_done(uv_recovered)
  );

  // Direct flags, one register stage from their sources
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_breaker_failure_trip_flag <= 1'b0;
      o_breaker_failure_retrip_flag <= 1'b0;
      o_phase_directional_flag <= 1'b0;
      o_neutral_directional_flag <= 1'b0;
      o_sync_check <= 1'b0;
    end else if (i_ce) begin
      o_breaker_failure_trip_flag <= i_bf_trip_event;
      o_breaker_failure_retrip_flag <= i_bf_retrip_event;
      o_phase_directional_flag <= in_sector(i_pos_seq_angle, phase_start);
      o_neutral_directional_flag <= in_sector(i_neg_seq_angle, neutral_start);
      o_sync_check <= i_sync_ok;
    end
  end

  // Undervoltage block: set below level, released only by recovery timer
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reclose_undervoltage_block <= 1'b0;
    end else if (i_ce) begin
      if (i_voltage < uv_setting) begin
        o_reclose_undervoltage_block <= 1'b1;
      end else if (uv_recovered) begin
        o_reclose_undervoltage_block <= 1'b0;
      end
    end
  end

  // Seal-ins follow the flags; a fresh event beats a reset in the same cycle
  assign seal_base = {o_sync_check, o_neutral_directional_flag, o_phase_directional_flag,
                      o_breaker_failure_retrip_flag, o_breaker_failure_trip_flag};

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_seal_in <= 5'h00;
    end else if (i_ce) begin
      o_seal_in <= seal_base | ((seal_reset || clear_all) ? 5'h00 : o_seal_in);
    end
  end

  // Latches: set wins over reset so a set pulse is never lost
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_latching_outputs <= 8'h00;
    end else if (i_ce) begin
      if (clear_all) begin
        o_latching_outputs <= i_latch_set;
      end else begin
        o_latching_outputs <= i_latch_set | (o_latching_outputs & ~i_latch_reset);
      end
    end
  end

  // Hot hold tag transitions; tag set wins when both inputs arrive in off
  always_comb begin
    case (tag_state)
      TAG_OFF: begin
        if (i_tag_set_input) begin
          next_tag_state = TAG_TAGGED;
        end else if (i_tag_release_input) begin
          next_tag_state = TAG_ON;
        end else begin
          next_tag_state = TAG_OFF;
        end
      end
      TAG_TAGGED: next_tag_state = i_tag_release_input ? TAG_OFF : TAG_TAGGED;
      TAG_ON: next_tag_state = i_tag_set_input ? TAG_OFF : TAG_ON;
      default: next_tag_state = TAG_OFF;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tag_state <= P_TAG_INIT;
    end else if (i_ce) begin
      tag_state <= next_tag_state;
    end
  end

  // State outputs are the one-hot state bits, so they never overlap
  assign o_tag_off_state_output = tag_state[0];
  assign o_tag_tagged_state_output = tag_state[1];
  assign o_tag_on_state_output = tag_state[2];

  // Close gating; the undervoltage block only suspends automatic reclosing
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_close_output <= 1'b0;
      o_reclose_output <= 1'b0;
    end else if (i_ce) begin
      o_close_output <= i_manual_close && tag_state != TAG_TAGGED;
      // Raw compare too, so the first low-voltage cycle cannot slip a reclose through
      o_reclose_output <= i_reclose_request && tag_state == TAG_ON
                          && !o_reclose_undervoltage_block && !(i_voltage < uv_setting);
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_b);

  bft_follow_a: assert property (i_ce |=> o_breaker_failure_trip_flag == $past(i_bf_trip_event))
    else $error("trip flag does not follow event");
  retrip_follow_a: assert property (i_ce |=> o_breaker_failure_retrip_flag == $past(i_bf_retrip_event))
    else $error("retrip flag does not follow event");
  sync_follow_a: assert property (i_ce |=> o_sync_check == $past(i_sync_ok))
    else $error("sync output wrong");
  power_drop_a: assert property (i_ce && i_pos_power <= pwr_thr_two |=> !o_positive_power_alarm_two)
    else $error("alarm two set below threshold");
  tag_exclusive_a: assert property ($onehot({o_tag_off_state_output, o_tag_tagged_state_output, o_tag_on_state_output}))
    else $error("tag states overlap");
  tag_set_off_a: assert property (i_ce && o_tag_off_state_output && i_tag_set_input |=> o_tag_tagged_state_output)
    else $error("tag set ignored in off");
  tag_release_on_a: assert property (i_ce && o_tag_off_state_output && !i_tag_set_input
      && i_tag_release_input |=> o_tag_on_state_output)
    else $error("release did not enter on");
  close_block_a: assert property (i_ce && o_tag_tagged_state_output |=> !o_close_output)
    else $error("close while tagged");
  seal_hold_a: assert property (i_ce && o_seal_in[0] && !seal_reset && !clear_all |=> o_seal_in[0])
    else $error("seal-in dropped without reset");
  uv_block_a: assert property (i_ce && i_voltage < uv_setting |=> o_reclose_undervoltage_block ##0 !o_reclose_output)
    else $error("undervoltage block missing");
  latch_set_a: assert property (i_ce && i_latch_set[0] |=> o_latching_outputs[0])
    else $error("latch not set");

  alarm_two_c: cover property ($rose(o_positive_power_alarm_two));
  tag_on_c: cover property ($rose(o_tag_on_state_output));
  uv_release_c: cover property ($fell(o_reclose_undervoltage_block));
endmodule

// ==== testbench/field_model.sv ====
// Stands in for the measurement comparators and the recloser feeding the block
module field_model (
  input wire logic i_tag_on,
  output logic [15:0] o_power,
  output logic [15:0] o_volt,
  output logic [8:0] o_pos_ang,
  output logic [8:0] o_neg_ang,
  output logic o_brk_op,
  output logic o_reclose_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic want_reclose; // Recloser asks to close
  // Quiet system at power-up: no load, healthy voltage
  initial begin
    o_power = 16'h0000;
    o_volt = 16'h0800;
    // Angles outside both default sectors, so no directional flag at rest
    o_pos_ang = 9'h10e;
    o_neg_ang = 9'h10e;
    o_brk_op = 1'b0;
    want_reclose = 1'b0;
  end
  // Reclose enable is the on-state output fed back, so reclose needs the tag on
  assign o_reclose_req = want_reclose & i_tag_on;
endmodule

// ==== testbench/prot_logic_bench.sv ====
module prot_logic_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import prot_logic_pkg::*;
  `define CK(a, e) chk(32'(a), 32'(e))
  `define FM field_model_inst
  localparam int ANG [4] = '{0, 179, 180, 359}; // Sector edges
  logic clk, rst_b, req, we, ack; // Clock, reset, bus handshake
  logic [7:0] adr;
  logic [31:0] wdat, rd, rdat; // Write data, bus read data, captured read
  logic breaker_failure_trip_flag, rtp, syn, tset, trel, mcl; // Events and tag controls
  logic [7:0] lset, lrst;
  logic [15:0] pwr, volt, uo;
  logic [8:0] pang, nang;
  logic brk, rcl, a1, a2, fbt, frt, fph, fne, fsy, fsb, fuv, toff, ttag, ton, cls, rco;
  logic [4:0] seal;
  logic [7:0] lat;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  // Short tick and alarm counts keep the run brief
  prot_logic #(.P_TICK_CYCLES(4), .P_ALARM_TICKS(5), .P_TAG_INIT(TAG_OFF)) prot_logic_inst (
    .i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(1'b1), .i_wb_cyc(req), .i_wb_stb(req),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat), .o_wb_dat(rd),
    .o_wb_ack(ack), .i_pos_power(pwr), .i_pos_seq_angle(pang), .i_neg_seq_angle(nang),
    .i_bf_trip_event(breaker_failure_trip_flag), .i_bf_retrip_event(rtp), .i_sync_ok(syn),
    .i_breaker_operating(brk), .i_voltage(volt), .i_latch_set(lset), .i_latch_reset(lrst),
    .i_tag_set_input(tset), .i_tag_release_input(trel), .i_manual_close(mcl),
    .i_reclose_request(rcl), .o_positive_power_alarm_one(a1), .o_positive_power_alarm_two(a2),
    .o_breaker_failure_trip_flag(fbt), .o_breaker_failure_retrip_flag(frt),
    .o_phase_directional_flag(fph), .o_neutral_directional_flag(fne), .o_sync_check(fsy),
    .o_slow_breaker_alarm(fsb), .o_reclose_undervoltage_block(fuv), .o_seal_in(seal),
    .o_latching_outputs(lat), .o_user_logic_outputs(uo), .o_tag_off_state_output(toff),
    .o_tag_tagged_state_output(ttag), .o_tag_on_state_output(ton), .o_close_output(cls),
    .o_reclose_output(rco));

  field_model field_model_inst (.i_tag_on(ton), .o_power(pwr), .o_volt(volt),
    .o_pos_ang(pang), .o_neg_ang(nang), .o_brk_op(brk), .o_reclose_req(rcl));

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      end_sim;
    end
  end

  task end_sim;
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask

  // Classic single cycle; holds everything until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = rd;
    req <= 1'b0;
  endtask

  task clks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One-cycle pulse on the tag inputs, sampled at the negedge after
  task tag_pulse(input logic s, input logic r);
    @(posedge clk) tset <= s;
    trel <= r;
    @(posedge clk) tset <= 1'b0;
    trel <= 1'b0;
    @(negedge clk);
  endtask

  task t_reset;
    wb(1'b0, OFS_PWR_THR_TWO, 32'h0);
    `CK(rdat, RST_PWR_THR);
    wb(1'b0, OFS_STATUS, 32'h0);
    `CK(rdat, 32'h0000_0200);
    `CK(uo, 16'h0000);
    wb(1'b1, OFS_USER_OUT, 32'h0000_a55a);
    wb(1'b1, 8'h3c, 32'h0000_ffff); // Unmapped, must not disturb anything
    @(negedge clk) `CK(uo, 16'ha55a);
    $display("test reset done");
  endtask

  task t_flags;
    @(posedge clk) breaker_failure_trip_flag <= 1'b1;
    rtp <= 1'b1;
    syn <= 1'b1;
    @(posedge clk) breaker_failure_trip_flag <= 1'b0;
    rtp <= 1'b0;
    syn <= 1'b0;
    @(negedge clk) `CK({fbt, frt, fsy}, 3'b111);
    clks(2);
    @(negedge clk) `CK({fbt, frt, fsy}, 3'b000);
    `CK(seal, 5'b10011);
    wb(1'b1, OFS_CTRL, 32'h1);
    clks(2);
    @(negedge clk) `CK(seal, 5'b00000);
    $display("test flags done");
  endtask

  // Neutral sector starts at 100, so its angles are offset by 100
  task t_dir;
    wb(1'b1, OFS_NEUTRAL_SECTOR, 32'd100);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) `FM.o_pos_ang <= 9'(ANG[i]);
      `FM.o_neg_ang <= 9'((ANG[i] + 100) % 360);
      clks(2);
      @(negedge clk) `CK(fph, ANG[i] < 180);
      `CK(fne, ANG[i] < 180);
    end
    `CK(seal[3:2], 2'b11);
    $display("test directional done");
  endtask

  // Alarm two armed; alarm one threshold equals the load, so not above it until lowered to 0x1ff
  task t_power;
    wb(1'b1, OFS_PWR_THR_TWO, 32'h0100);
    wb(1'b1, OFS_PWR_THR_ONE, 32'h0200);
    @(posedge clk) `FM.o_power <= 16'h0200;
    clks(12);
    @(negedge clk) `CK(a2, 1'b0);
    @(posedge clk) `FM.o_power <= 16'h0100;
    clks(3);
    `FM.o_power <= 16'h0200;
    clks(12);
    @(negedge clk) `CK(a2, 1'b0);
    clks(20);
    @(negedge clk) `CK(a2, 1'b1);
    `CK(a1, 1'b0);
    wb(1'b1, OFS_PWR_THR_ONE, 32'h01ff);
    clks(24);
    @(negedge clk) `CK(a1, 1'b1);
    @(posedge clk) `FM.o_power <= 16'h0000;
    $display("test power done");
  endtask

  task t_slow;
    wb(1'b1, OFS_SLOW_TIME, 32'd3);
    @(posedge clk) `FM.o_brk_op <= 1'b1;
    clks(1);
    @(negedge clk) `CK(fsb, 1'b0);
    clks(20);
    @(negedge clk) `CK(fsb, 1'b1);
    @(posedge clk) `FM.o_brk_op <= 1'b0;
    $display("test slow breaker done");
  endtask

  task t_latch;
    @(posedge clk) lset <= 8'h81;
    @(posedge clk) lset <= 8'h00;
    @(negedge clk) `CK(lat, 8'h81);
    @(posedge clk) lrst <= 8'h01;
    @(posedge clk) lrst <= 8'h00;
    @(negedge clk) `CK(lat, 8'h80);
    @(posedge clk) breaker_failure_trip_flag <= 1'b1;
    @(posedge clk) breaker_failure_trip_flag <= 1'b0;
    clks(2);
    wb(1'b1, OFS_CTRL, 32'h2);
    clks(2);
    @(negedge clk) `CK({seal, lat}, 13'h0000);
    $display("test latch done");
  endtask

  task t_tag;
    tag_pulse(1'b0, 1'b1);
    `CK({toff, ttag, ton}, 3'b001);
    @(posedge clk) mcl <= 1'b1;
    `FM.want_reclose <= 1'b1;
    @(posedge clk) mcl <= 1'b0;
    `FM.want_reclose <= 1'b0;
    @(negedge clk) `CK({cls, rco}, 2'b11);
    tag_pulse(1'b1, 1'b0);
    `CK({toff, ttag, ton}, 3'b100);
    tag_pulse(1'b1, 1'b0);
    `CK({toff, ttag, ton}, 3'b010);
    @(posedge clk) mcl <= 1'b1;
    @(posedge clk) mcl <= 1'b0;
    @(negedge clk) `CK(cls, 1'b0);
    tag_pulse(1'b0, 1'b1);
    `CK({toff, ttag, ton}, 3'b100);
    tag_pulse(1'b0, 1'b1);
    $display("test tag done");
  endtask

  // Runs with the tag on, so only the block can stop a reclose
  task t_uv;
    wb(1'b1, OFS_UV_SETTING, 32'd1000);
    wb(1'b1, OFS_UV_DELAY, 32'd3);
    @(posedge clk) `FM.o_volt <= 16'd500;
    clks(1);
    @(negedge clk) `CK(fuv, 1'b1);
    @(posedge clk) `FM.want_reclose <= 1'b1;
    @(posedge clk) `FM.want_reclose <= 1'b0;
    @(negedge clk) `CK(rco, 1'b0);
    @(posedge clk) `FM.o_volt <= 16'd2000;
    clks(1);
    @(negedge clk) `CK(fuv, 1'b1);
    clks(20);
    @(negedge clk) `CK(fuv, 1'b0);
    $display("test undervoltage done");
  endtask

  // Main sequence
  initial begin
    rst_b = 1'b0;
    {req, we, adr, wdat, breaker_failure_trip_flag, rtp, syn, tset, trel, mcl, lset, lrst} = '0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_flags;
    t_dir;
    t_power;
    t_slow;
    t_latch;
    t_tag;
    t_uv;
    end_sim;
  end
endmodule
